// ===== tb/mdp_bench.sv
// Purpose: self-checking bench for the data path slice
// Assumes: design answers one cycle after each strobe
// Notes: integer model tracks accumulator and status; fixed seed
`timescale 1ns/10ps
`default_nettype none
module mcu_data_path_status_irq_bench;
    // stimulus, all given values at time zero
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic exec_in = 1'b0, use_imm_in = 1'b0, dest_acc_in = 1'b0;
    mdp_pkg::mdp_op_e op_in = mdp_pkg::OP_ADD;
    logic [7:0] addr_in = 8'h00, imm_in = 8'h00, disp_rdata_in = 8'h00;
    logic halt_in = 1'b0, wdt_clear_in = 1'b0, wdt_timeout_in = 1'b0, reti_in = 1'b0;
    logic stack_full_in = 1'b0, ack_slot_in = 1'b0;
    logic [5:0] irq_req_in = 6'h00;
    // observed outputs
    logic [7:0] disp_raddr_out, disp_waddr_out, disp_wdata_out, acc_out, status_out;
    logic disp_we_out, skip_out, irq_ack_out, halted_out, wake_out;
    logic [11:0] irq_vector_out;
    // model state and bookkeeping
    int num_errors = 0, checks = 0, seed = 85152, a = 0, st = 0, i, k;
    mdp_pkg::mdp_op_e ops[7] = '{mdp_pkg::OP_ADD, mdp_pkg::OP_ADC, mdp_pkg::OP_SUB, mdp_pkg::OP_SBC,
        mdp_pkg::OP_AND, mdp_pkg::OP_OR, mdp_pkg::OP_XOR};

    mdp_core mdp_core_i (.mclk_in(mclk_in), .rst_in(rst_in), .exec_in(exec_in), .op_in(op_in),
        .addr_in(addr_in), .imm_in(imm_in), .use_imm_in(use_imm_in), .dest_acc_in(dest_acc_in),
        .halt_in(halt_in), .wdt_clear_in(wdt_clear_in), .wdt_timeout_in(wdt_timeout_in),
        .reti_in(reti_in), .stack_full_in(stack_full_in), .ack_slot_in(ack_slot_in),
        .irq_req_in(irq_req_in), .disp_raddr_out(disp_raddr_out), .disp_rdata_in(disp_rdata_in),
        .disp_we_out(disp_we_out), .disp_waddr_out(disp_waddr_out), .disp_wdata_out(disp_wdata_out),
        .acc_out(acc_out), .status_out(status_out), .skip_out(skip_out), .irq_ack_out(irq_ack_out),
        .irq_vector_out(irq_vector_out), .halted_out(halted_out), .wake_out(wake_out));

    // free-running 100 MHz clock
    initial
    begin
        forever #5 mclk_in = ~mclk_in;
    end

    // one compare for every result; four-state equality so x never matches
    task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one instruction: strobe for one edge, sample just after the answer edge
    task automatic ins(input mdp_pkg::mdp_op_e o, input logic [7:0] ad, input logic [7:0] im, input logic ui);
        @(posedge mclk_in);
        exec_in <= 1'b1;
        op_in <= o;
        addr_in <= ad;
        imm_in <= im;
        use_imm_in <= ui;
        dest_acc_in <= (o != mdp_pkg::OP_STA);
        @(posedge mclk_in);
        exec_in <= 1'b0;
        #1;
    endtask

    // one-cycle sequencer event pulses
    task automatic ev(input logic h, input logic c, input logic t, input logic r, input logic [5:0] q);
        @(posedge mclk_in);
        {halt_in, wdt_clear_in, wdt_timeout_in, reti_in, irq_req_in} <= {h, c, t, r, q};
        @(posedge mclk_in);
        {halt_in, wdt_clear_in, wdt_timeout_in, reti_in, irq_req_in} <= 10'h000;
        #1;
    endtask

    // register write always goes through the accumulator
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        ins(mdp_pkg::OP_LDA, 8'h00, v, 1'b1);
        ins(mdp_pkg::OP_STA, ad, 8'h00, 1'b0);
        a = v;
    endtask

    // arithmetic or logic op with immediate, checked against the model
    task automatic ar(input mdp_pkg::mdp_op_e o, input int b);
        int x, ci, s, r;
        x = (o inside {mdp_pkg::OP_SUB, mdp_pkg::OP_SBC}) ? 8'hff - b : b;
        ci = (o == mdp_pkg::OP_ADD) ? 0 : (o == mdp_pkg::OP_SUB) ? 1 : st & 1;
        s = a + x + ci;
        r = s & 8'hff;
        if (o inside {mdp_pkg::OP_AND, mdp_pkg::OP_OR, mdp_pkg::OP_XOR})
        begin
            r = (o == mdp_pkg::OP_AND) ? a & b : (o == mdp_pkg::OP_OR) ? a | b : a ^ b;
            st = (st & 8'hfb) | ((r == 0) << 2);
        end
        else
        begin
            st = (st & 8'hf0) | (((((a & 8'h7f) + (x & 8'h7f) + ci) >> 7) ^ (s >> 8)) << 3) | ((r == 0) << 2)
                | ((((a & 8'h0f) + (x & 8'h0f) + ci) >> 4) << 1) | (s >> 8);
        end
        a = r;
        ins(o, 8'h00, b[7:0], 1'b1);
        cmp("acc", a[7:0], acc_out);
        cmp("status", st[7:0], status_out);
    endtask

    // closing report, the single end of the run
    task automatic test_done();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #200000;
        num_errors++;
        test_done();
    end

    // main sequence
    initial
    begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        disp_rdata_in <= 8'($random(seed));
        #1;
        cmp("status", 8'h00, status_out);
        // random arithmetic, then a forced zero result
        for (i = 0; i < 40; i++)
            ar(ops[($random(seed) & 32'h7fffffff) % 7], $random(seed) & 8'hff);
        ar(mdp_pkg::OP_SUB, a);
        ins(mdp_pkg::OP_SZ, 8'h00, 8'h00, 1'b1);
        cmp("skip", 1'b1, skip_out);
        ins(mdp_pkg::OP_SZ, 8'h00, 8'h01, 1'b1);
        cmp("skip", 1'b0, skip_out);
        // skips, complement, decimal adjust, rotates, inc/dec; status[3:0] is 7h here
        ins(mdp_pkg::OP_SIZ, 8'h00, 8'hff, 1'b1);
        cmp("siz", 12'h100, {skip_out, acc_out});
        ins(mdp_pkg::OP_SDZ, 8'h00, 8'h05, 1'b1);
        cmp("sdz", 12'h004, {skip_out, acc_out});
        ins(mdp_pkg::OP_SNZ, 8'h00, 8'h05, 1'b1);
        cmp("snz", 12'h104, {skip_out, acc_out});
        ins(mdp_pkg::OP_CPL, 8'h00, 8'h0f, 1'b1);
        cmp("cpl", 12'h3f0, {status_out[3:0], acc_out});
        ins(mdp_pkg::OP_DAA, 8'h00, 8'h00, 1'b1);
        cmp("daa", 12'h356, {status_out[3:0], acc_out});
        ins(mdp_pkg::OP_RR, 8'h00, 8'h01, 1'b1);
        cmp("rr", 12'h380, {status_out[3:0], acc_out});
        ins(mdp_pkg::OP_INC, 8'h00, 8'hff, 1'b1);
        cmp("inc", 12'h700, {status_out[3:0], acc_out});
        ins(mdp_pkg::OP_RLC, 8'h00, 8'h40, 1'b1);
        cmp("rlc", 12'h681, {status_out[3:0], acc_out});
        ins(mdp_pkg::OP_RL, 8'h00, 8'h81, 1'b1);
        cmp("rl", 12'h603, {status_out[3:0], acc_out});
        ins(mdp_pkg::OP_RRC, 8'h00, 8'h03, 1'b1);
        cmp("rrc", 12'h701, {status_out[3:0], acc_out});
        ins(mdp_pkg::OP_DEC, 8'h00, 8'h02, 1'b1);
        cmp("dec", 12'h301, {status_out[3:0], acc_out});
        $display("test alu done");
        // windows, nested access and display through pointer b
        wr(8'h01, 8'h70);
        wr(8'h00, 8'h5a);
        ins(mdp_pkg::OP_LDA, 8'h70, 8'h00, 1'b0);
        cmp("acc", 8'h5a, acc_out);
        wr(8'h01, 8'h02);
        wr(8'h00, 8'h33);
        ins(mdp_pkg::OP_LDA, 8'h00, 8'h00, 1'b0);
        cmp("acc", 8'h00, acc_out);
        wr(8'h01, 8'h70);
        ins(mdp_pkg::OP_LDA, 8'h00, 8'h00, 1'b0);
        cmp("acc", 8'h5a, acc_out);
        wr(8'h03, 8'h45);
        wr(8'h02, 8'h3c);
        cmp("disp", 12'h13c, {3'h0, disp_we_out, disp_wdata_out});
        cmp("disp_addr", 8'h05, disp_waddr_out);
        ins(mdp_pkg::OP_LDA, 8'h02, 8'h00, 1'b0);
        cmp("acc", disp_rdata_in, acc_out);
        cmp("disp_raddr", 8'h05, disp_raddr_out);
        // accumulator as memory operand, move through accumulator
        wr(8'h61, 8'h21);
        ins(mdp_pkg::OP_ADD, 8'h05, 8'h00, 1'b0);
        cmp("acc", 8'h42, acc_out);
        ins(mdp_pkg::OP_LDA, 8'h61, 8'h00, 1'b0);
        cmp("acc", 8'h21, acc_out);
        $display("test memory done");
        // status write and power flags, wake from every source
        wr(8'h0a, 8'hff);
        cmp("status", 8'h0f, status_out);
        for (i = 0; i < 6; i++)
        begin
            ev(1'b1, 1'b0, 1'b0, 1'b0, 6'h00);
            cmp("halted", 1'b1, halted_out);
            ev(1'b0, 1'b0, 1'b0, 1'b0, 6'(1 << i));
            cmp("wake", 2'h2, {wake_out, halted_out});
        end
        cmp("status", 8'h1f, status_out);
        ev(1'b0, 1'b0, 1'b1, 1'b0, 6'h00);
        cmp("status", 8'h3f, status_out);
        wr(8'h0a, 8'h00);
        cmp("status", 8'h30, status_out);
        ev(1'b0, 1'b1, 1'b0, 1'b0, 6'h00);
        cmp("status", 8'h00, status_out);
        $display("test status done");
        // interrupts: stack full holds off, then priority order with reti
        stack_full_in <= 1'b1;
        ack_slot_in <= 1'b1;
        wr(8'h0b, 8'h0f);
        wr(8'h1e, 8'h07);
        ev(1'b0, 1'b0, 1'b0, 1'b0, 6'h3f);
        repeat (3) @(posedge mclk_in);
        #1;
        cmp("ack", 1'b0, irq_ack_out);
        stack_full_in <= 1'b0;
        for (i = 0; i < 6; i++)
        begin
            for (k = 0; k < 8 && irq_ack_out !== 1'b1; k++)
                @(posedge mclk_in) #1;
            cmp("ack", 1'b1, irq_ack_out);
            cmp("vector", 12'(12'h004 + 4 * i), irq_vector_out);
            repeat (2) @(posedge mclk_in);
            #1;
            cmp("ack", 1'b0, irq_ack_out);
            ev(1'b0, 1'b0, 1'b0, 1'b1, 6'h00);
        end
        ack_slot_in <= 1'b0;
        ins(mdp_pkg::OP_LDA, 8'h0b, 8'h00, 1'b0);
        cmp("ctl_first", 8'h0f, acc_out);
        ins(mdp_pkg::OP_LDA, 8'h1e, 8'h00, 1'b0);
        cmp("ctl_second", 8'h07, acc_out);
        $display("test irq done");
        test_done();
    end
endmodule
`default_nettype wire

// ===== verilog/mdp_alu.sv
// Purpose: 8-bit combinational arithmetic and logic unit
// Assumes: driven from the core each instruction cycle
// Notes: subtraction is a minus b, carry means no borrow
`timescale 1ns/10ps
`default_nettype none
module mdp_alu (
    // operand and result bundle
    mdp_alu_if.alu alu
);
    logic [7:0] y; // second operand, inverted for subtract
    logic ci; // effective carry in
    logic [8:0] s9; // full sum
    logic [4:0] lo5; // low nibble sum
    logic [7:0] s7; // sum of bits 6:0, bit7 is carry into msb
    logic [8:0] d9; // decimal adjust work value
    logic [3:0] cz; // flag scratch

    // carry chain shared by all add/sub forms
    always_comb
    begin
        y = alu.b;
        ci = 1'b0;
        if (alu.op == mdp_pkg::OP_SUB || alu.op == mdp_pkg::OP_SBC)
        begin
            y = ~alu.b;
        end
        if (alu.op == mdp_pkg::OP_ADC || alu.op == mdp_pkg::OP_SBC)
        begin
            ci = alu.c_in;
        end
        else if (alu.op == mdp_pkg::OP_SUB)
        begin
            ci = 1'b1;
        end
        s9 = {1'b0, alu.a} + {1'b0, y} + {8'h00, ci};
        lo5 = {1'b0, alu.a[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        s7 = {1'b0, alu.a[6:0]} + {1'b0, y[6:0]} + {7'h00, ci};
        d9 = {1'b0, alu.a};
        if (alu.a[3:0] > mdp_pkg::DAA_NIB_MAX || alu.ac_in)
        begin
            d9 = d9 + mdp_pkg::DAA_LO_ADJ;
        end
        if (d9[7:4] > mdp_pkg::DAA_NIB_MAX || alu.c_in || d9[8])
        begin
            d9 = d9 + mdp_pkg::DAA_HI_ADJ;
        end
    end

    // operation select and flag mask
    always_comb
    begin
        alu.res = alu.b;
        alu.upd = 4'h0;
        alu.wr = 1'b1;
        alu.skip = 1'b0;
        cz = 4'h0;
        unique case (alu.op)
            mdp_pkg::OP_ADD, mdp_pkg::OP_ADC, mdp_pkg::OP_SUB, mdp_pkg::OP_SBC:
            begin
                alu.res = s9[7:0];
                cz[mdp_pkg::ST_C] = s9[8];
                cz[mdp_pkg::ST_AC] = lo5[4];
                cz[mdp_pkg::ST_OV] = s7[7] ^ s9[8];
                alu.upd = 4'hf;
            end
            mdp_pkg::OP_DAA:
            begin
                alu.res = d9[7:0];
                cz[mdp_pkg::ST_C] = d9[8];
                alu.upd = 4'h1;
            end
            mdp_pkg::OP_AND: begin alu.res = alu.a & alu.b; alu.upd = 4'h4; end
            mdp_pkg::OP_OR: begin alu.res = alu.a | alu.b; alu.upd = 4'h4; end
            mdp_pkg::OP_XOR: begin alu.res = alu.a ^ alu.b; alu.upd = 4'h4; end
            mdp_pkg::OP_CPL: begin alu.res = ~alu.b; alu.upd = 4'h4; end
            mdp_pkg::OP_RL: alu.res = {alu.b[6:0], alu.b[7]};
            mdp_pkg::OP_RR: alu.res = {alu.b[0], alu.b[7:1]};
            mdp_pkg::OP_RLC:
            begin
                alu.res = {alu.b[6:0], alu.c_in};
                cz[mdp_pkg::ST_C] = alu.b[7];
                alu.upd = 4'h1;
            end
            mdp_pkg::OP_RRC:
            begin
                alu.res = {alu.c_in, alu.b[7:1]};
                cz[mdp_pkg::ST_C] = alu.b[0];
                alu.upd = 4'h1;
            end
            mdp_pkg::OP_INC: begin alu.res = alu.b + 8'h01; alu.upd = 4'h4; end
            mdp_pkg::OP_DEC: begin alu.res = alu.b - 8'h01; alu.upd = 4'h4; end
            mdp_pkg::OP_SZ: begin alu.wr = 1'b0; alu.skip = (alu.b == 8'h00); end
            mdp_pkg::OP_SNZ: begin alu.wr = 1'b0; alu.skip = (alu.b != 8'h00); end
            mdp_pkg::OP_SIZ: begin alu.res = alu.b + 8'h01; alu.skip = (alu.b == 8'hff); end
            mdp_pkg::OP_SDZ: begin alu.res = alu.b - 8'h01; alu.skip = (alu.b == 8'h01); end
            mdp_pkg::OP_LDA: alu.res = alu.b;
            mdp_pkg::OP_STA: alu.res = alu.a;
            // unused op codes write nothing and leave flags alone
            default:
            begin
                alu.wr = 1'b0;
            end
        endcase
        cz[mdp_pkg::ST_Z] = (alu.res == 8'h00);
        alu.flg = cz;
    end
endmodule
`default_nettype wire

// ===== verilog/mdp_alu_if.sv
// Purpose: operand and result bundle between core and alu
// Assumes: purely combinational exchange
// Notes: flags ordered {ov, z, ac, c} like status bits 3:0
`timescale 1ns/10ps
`default_nettype none
interface mdp_alu_if;
    mdp_pkg::mdp_op_e op; // operation
    logic [7:0] a; // accumulator operand
    logic [7:0] b; // memory or immediate operand
    logic c_in; // carry in
    logic ac_in; // nibble carry in
    logic [7:0] res; // result
    logic [3:0] flg; // new flag values
    logic [3:0] upd; // which flags change
    logic wr; // result is written back
    logic skip; // skip condition met
    modport core (output op, a, b, c_in, ac_in, input res, flg, upd, wr, skip);
    modport alu (input op, a, b, c_in, ac_in, output res, flg, upd, wr, skip);
endinterface
`default_nettype wire

// ===== verilog/mdp_core.sv
// Purpose: data path slice: windows, pointers, accumulator, status, irq
// Assumes: exec/halt/irq strobes come from logic on mclk_in
// Notes: external pin requests are synchronised before irq_req_in
`timescale 1ns/10ps
`default_nettype none
module mdp_core (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // instruction strobe and operands
    input wire logic exec_in,
    input wire mdp_pkg::mdp_op_e op_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] imm_in,
    input wire logic use_imm_in,
    input wire logic dest_acc_in,
    // sequencer events
    input wire logic halt_in,
    input wire logic wdt_clear_in,
    input wire logic wdt_timeout_in,
    input wire logic reti_in,
    input wire logic stack_full_in,
    input wire logic ack_slot_in,
    input wire logic [5:0] irq_req_in,
    // display memory port
    output logic [7:0] disp_raddr_out,
    input wire logic [7:0] disp_rdata_in,
    output logic disp_we_out,
    output logic [7:0] disp_waddr_out,
    output logic [7:0] disp_wdata_out,
    // visible state
    output logic [7:0] acc_out,
    output logic [7:0] status_out,
    output logic skip_out,
    // interrupt and power results
    output logic irq_ack_out,
    output logic [11:0] irq_vector_out,
    output logic halted_out,
    output logic wake_out
);
    mdp_pkg::mdp_state_s s_r; // all state
    mdp_pkg::mdp_state_s s_nxt; // next state
    logic [7:0] eff; // resolved data address
    logic via_b; // access went through pointer b
    logic nul; // nested window access
    logic [7:0] rd; // operand read from memory
    logic [7:0] ridx; // ram index
    logic to_acc; // write back goes to accumulator
    logic [5:0] pend; // enabled pending requests
    logic take; // acknowledge this cycle
    logic [2:0] idx; // winning source
    logic [5:0] oh; // winning source one-hot
    mdp_alu_if alu_bus ();

    mdp_alu u_alu (
        .alu(alu_bus)
    );

    // address resolution through the windows
    always_comb
    begin
        eff = addr_in;
        via_b = 1'b0;
        nul = 1'b0;
        if (addr_in == mdp_pkg::ADDR_WIN_A)
        begin
            eff = s_r.pa;
            nul = (s_r.pa == mdp_pkg::ADDR_WIN_A) || (s_r.pa == mdp_pkg::ADDR_WIN_B);
        end
        else if (addr_in == mdp_pkg::ADDR_WIN_B)
        begin
            eff = s_r.pb;
            via_b = 1'b1;
            nul = (s_r.pb == mdp_pkg::ADDR_WIN_A) || (s_r.pb == mdp_pkg::ADDR_WIN_B);
        end
        // a window-to-window move needs two indirect reads in one op; no path exists
        ridx = eff - mdp_pkg::ADDR_RAM_LO;
        disp_raddr_out = eff - mdp_pkg::ADDR_DISP_LO;
    end

    // operand read mux; unmapped or foreign addresses read zero
    always_comb
    begin
        rd = 8'h00;
        if (!nul)
        begin
            case (eff)
                mdp_pkg::ADDR_PTR_A: rd = s_r.pa;
                mdp_pkg::ADDR_PTR_B: rd = s_r.pb;
                mdp_pkg::ADDR_ACC: rd = s_r.acc;
                mdp_pkg::ADDR_STATUS: rd = s_r.st;
                mdp_pkg::ADDR_IRQ_CONTROL_FIRST: rd = s_r.ic0;
                mdp_pkg::ADDR_IRQ_CONTROL_SECOND: rd = s_r.ic1;
                default:
                begin
                    if (eff >= mdp_pkg::ADDR_RAM_LO)
                    begin
                        rd = s_r.ram[ridx];
                    end
                    else if (via_b && eff >= mdp_pkg::ADDR_DISP_LO && eff <= mdp_pkg::ADDR_DISP_HI)
                    begin
                        rd = disp_rdata_in;
                    end
                end
            endcase
        end
    end

    // alu operands: accumulator against memory or immediate
    always_comb
    begin
        alu_bus.op = op_in;
        alu_bus.a = s_r.acc;
        alu_bus.b = use_imm_in ? imm_in : rd;
        alu_bus.c_in = s_r.st[mdp_pkg::ST_C];
        alu_bus.ac_in = s_r.st[mdp_pkg::ST_AC];
        // loads land in acc, stores leave it, so memory never feeds memory
        to_acc = (op_in == mdp_pkg::OP_LDA) || (op_in != mdp_pkg::OP_STA && (dest_acc_in || use_imm_in));
    end

    // enabled pending requests and fixed priority pick
    always_comb
    begin
        pend[2:0] = s_r.ic0[mdp_pkg::IC_FLAG_LO +: 3] & s_r.ic0[mdp_pkg::IC0_EN_LO +: 3];
        pend[5:3] = s_r.ic1[mdp_pkg::IC_FLAG_LO +: 3] & s_r.ic1[mdp_pkg::IC1_EN_LO +: 3];
        idx = 3'h0;
        for (int i = mdp_pkg::IRQ_NUM - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                idx = 3'(i);
            end
        end
        oh = 6'h01 << idx;
        // full stack holds acknowledge until a return pops it
        take = (s_r.run == mdp_pkg::RUN_ACTIVE) && ack_slot_in && s_r.ic0[mdp_pkg::IC_EMI]
            && !stack_full_in && (pend != 6'h00);
    end

    // next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.skip = 1'b0;
        s_nxt.ack = 1'b0;
        s_nxt.wake = 1'b0;
        s_nxt.dwe = 1'b0;
        // instruction execution, frozen while halted
        if (exec_in && s_r.run == mdp_pkg::RUN_ACTIVE)
        begin
            if (alu_bus.wr && to_acc)
            begin
                s_nxt.acc = alu_bus.res;
            end
            else if (alu_bus.wr && !nul) // nested window write does nothing
            begin
                case (eff)
                    mdp_pkg::ADDR_PTR_A: s_nxt.pa = alu_bus.res;
                    mdp_pkg::ADDR_PTR_B: s_nxt.pb = alu_bus.res;
                    mdp_pkg::ADDR_ACC: s_nxt.acc = alu_bus.res;
                    mdp_pkg::ADDR_STATUS: s_nxt.st[3:0] = alu_bus.res[3:0];
                    mdp_pkg::ADDR_IRQ_CONTROL_FIRST: s_nxt.ic0 = alu_bus.res & mdp_pkg::IC0_MASK;
                    mdp_pkg::ADDR_IRQ_CONTROL_SECOND: s_nxt.ic1 = alu_bus.res & mdp_pkg::IC1_MASK;
                    default:
                    begin
                        if (eff >= mdp_pkg::ADDR_RAM_LO)
                        begin
                            s_nxt.ram[ridx] = alu_bus.res;
                        end
                        else if (via_b && eff >= mdp_pkg::ADDR_DISP_LO && eff <= mdp_pkg::ADDR_DISP_HI)
                        begin
                            s_nxt.dwe = 1'b1;
                            s_nxt.dwa = disp_raddr_out;
                            s_nxt.dwd = alu_bus.res;
                        end
                    end
                endcase
            end
            // flags win over a plain status write in the same op
            s_nxt.st[3:0] = (s_nxt.st[3:0] & ~alu_bus.upd) | (alu_bus.flg & alu_bus.upd);
            s_nxt.skip = alu_bus.skip;
        end
        // power flags, only these events move them
        if (wdt_clear_in)
        begin
            s_nxt.st[mdp_pkg::ST_PDF] = 1'b0;
            s_nxt.st[mdp_pkg::ST_TO] = 1'b0;
        end
        if (halt_in && s_r.run == mdp_pkg::RUN_ACTIVE)
        begin
            s_nxt.st[mdp_pkg::ST_PDF] = 1'b1;
            s_nxt.st[mdp_pkg::ST_TO] = 1'b0;
            s_nxt.run = mdp_pkg::RUN_HALTED;
        end
        if (wdt_timeout_in)
        begin
            s_nxt.st[mdp_pkg::ST_TO] = 1'b1;
        end
        s_nxt.st[7:6] = 2'b00;
        // acknowledge: only pc is pushed by the sequencer, status is not
        if (take)
        begin
            s_nxt.ack = 1'b1;
            s_nxt.vec = mdp_pkg::IRQ_VEC[idx];
            s_nxt.ic0[mdp_pkg::IC_EMI] = 1'b0;
            s_nxt.ic0[mdp_pkg::IC_FLAG_LO +: 3] = s_nxt.ic0[mdp_pkg::IC_FLAG_LO +: 3] & ~oh[2:0];
            s_nxt.ic1[mdp_pkg::IC_FLAG_LO +: 3] = s_nxt.ic1[mdp_pkg::IC_FLAG_LO +: 3] & ~oh[5:3];
        end
        if (reti_in)
        begin
            s_nxt.ic0[mdp_pkg::IC_EMI] = 1'b1;
        end
        // new requests last, so a set beats any clear
        s_nxt.ic0[mdp_pkg::IC_FLAG_LO +: 3] = s_nxt.ic0[mdp_pkg::IC_FLAG_LO +: 3] | irq_req_in[2:0];
        s_nxt.ic1[mdp_pkg::IC_FLAG_LO +: 3] = s_nxt.ic1[mdp_pkg::IC_FLAG_LO +: 3] | irq_req_in[5:3];
        // any source request wakes, enabled or not
        if (s_r.run == mdp_pkg::RUN_HALTED && irq_req_in != 6'h00)
        begin
            s_nxt.run = mdp_pkg::RUN_ACTIVE;
            s_nxt.wake = 1'b1;
        end
    end

    // state register; power-up clears everything
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state
    assign acc_out = s_r.acc;
    assign status_out = s_r.st;
    assign skip_out = s_r.skip;
    assign irq_ack_out = s_r.ack;
    assign irq_vector_out = s_r.vec;
    assign halted_out = (s_r.run == mdp_pkg::RUN_HALTED);
    assign wake_out = s_r.wake;
    assign disp_we_out = s_r.dwe;
    assign disp_waddr_out = s_r.dwa;
    assign disp_wdata_out = s_r.dwd;

    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic [8:0] chk_sum; // reference sum for immediate add
    assign chk_sum = {1'b0, s_r.acc} + {1'b0, imm_in};

    nested_read_a: assert property (exec_in && !halted_out && op_in == mdp_pkg::OP_LDA
        && !use_imm_in && addr_in == mdp_pkg::ADDR_WIN_A && s_r.pa == mdp_pkg::ADDR_WIN_B
        |=> acc_out == 8'h00)
        else $error("nested window read not zero");
    status_top_zero_a: assert property (status_out[7:6] == 2'b00)
        else $error("status bits 7:6 not zero");
    status_write_keep_a: assert property (exec_in && op_in == mdp_pkg::OP_STA && addr_in == mdp_pkg::ADDR_STATUS
        && !halt_in && !wdt_clear_in && !wdt_timeout_in |=> $stable(status_out[5:4]))
        else $error("status write moved power flags");
    ack_drops_emi_a: assert property (irq_ack_out && !$past(reti_in) |-> !s_r.ic0[mdp_pkg::IC_EMI])
        else $error("global enable left set after ack");
    full_stack_hold_a: assert property (stack_full_in |=> !irq_ack_out)
        else $error("ack while stack full");
    ext0_vector_a: assert property (take && pend[0] |=> irq_ack_out && irq_vector_out == 12'h004
        && (!s_r.ic0[mdp_pkg::IC_FLAG_LO] || $past(irq_req_in[0])))
        else $error("external 0 vector or flag wrong");
    halt_flags_a: assert property (halt_in && !halted_out && !wdt_timeout_in |=> status_out[5:4] == 2'b01
        && halted_out)
        else $error("halt flags wrong");
    timeout_set_a: assert property (wdt_timeout_in |=> status_out[mdp_pkg::ST_TO])
        else $error("timeout flag not set");
    wake_any_a: assert property (halted_out && irq_req_in != 6'h00 |=> wake_out && !halted_out)
        else $error("no wake on request");
    add_imm_a: assert property (exec_in && !halted_out && op_in == mdp_pkg::OP_ADD && use_imm_in
        |=> acc_out == $past(chk_sum[7:0]) && status_out[mdp_pkg::ST_C] == $past(chk_sum[8]))
        else $error("immediate add result or carry wrong");
    ack_seen_c: cover property (take ##1 irq_ack_out ##[1:20] reti_in);
    wake_seen_c: cover property (halt_in ##[1:20] wake_out);
    skip_seen_c: cover property (exec_in && op_in == mdp_pkg::OP_SDZ ##1 skip_out);
    disp_seen_c: cover property (disp_we_out);
endmodule
`default_nettype wire

// ===== verilog/mdp_pkg.sv
// Purpose: shared constants and types for the mcu data path slice
// Assumes: one 100 MHz clock, instruction-level strobes from a sequencer
// Notes: Summary of operation list follows
`default_nettype none
package mdp_pkg;
    // register map
    localparam logic [7:0] ADDR_WIN_A = 8'h00;
    localparam logic [7:0] ADDR_PTR_A = 8'h01;
    localparam logic [7:0] ADDR_WIN_B = 8'h02;
    localparam logic [7:0] ADDR_PTR_B = 8'h03;
    localparam logic [7:0] ADDR_ACC = 8'h05;
    localparam logic [7:0] ADDR_STATUS = 8'h0a;
    localparam logic [7:0] ADDR_IRQ_CONTROL_FIRST = 8'h0b;
    localparam logic [7:0] ADDR_IRQ_CONTROL_SECOND = 8'h1e;
    localparam logic [7:0] ADDR_DISP_LO = 8'h40;
    localparam logic [7:0] ADDR_DISP_HI = 8'h5f;
    localparam logic [7:0] ADDR_RAM_LO = 8'h60;
    localparam int RAM_DEPTH = 160;
    // status bits
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_PDF = 4;
    localparam int ST_TO = 5;
    // irq control fields
    localparam int IC_EMI = 0;
    localparam int IC0_EN_LO = 1;
    localparam int IC1_EN_LO = 0;
    localparam int IC_FLAG_LO = 4;
    localparam logic [7:0] IC0_MASK = 8'h7f;
    localparam logic [7:0] IC1_MASK = 8'h77;
    localparam int IRQ_NUM = 6;
    // vectors, lowest index has highest priority
    localparam logic [5:0][11:0] IRQ_VEC = {12'h018, 12'h014, 12'h010, 12'h00c, 12'h008, 12'h004};
    // decimal adjust constants
    localparam logic [3:0] DAA_NIB_MAX = 4'h9;
    localparam logic [8:0] DAA_LO_ADJ = 9'h006;
    localparam logic [8:0] DAA_HI_ADJ = 9'h060;
    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA, OP_AND, OP_OR, OP_XOR,
        OP_CPL, OP_RL, OP_RR, OP_RLC, OP_RRC, OP_INC, OP_DEC,
        OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ, OP_LDA, OP_STA
    } mdp_op_e;
    typedef enum logic {RUN_ACTIVE, RUN_HALTED} mdp_run_e;
    typedef struct packed {
        mdp_run_e run;
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] acc;
        logic [7:0] st;
        logic [7:0] ic0;
        logic [7:0] ic1;
        logic [RAM_DEPTH-1:0][7:0] ram;
        logic skip;
        logic ack;
        logic wake;
        logic [11:0] vec;
        logic dwe;
        logic [7:0] dwa;
        logic [7:0] dwd;
    } mdp_state_s;
endpackage
`default_nettype wire
